//--- rtl/ovf_pkg.sv
package ovf_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_MOD_LO   = 4'h4;
    localparam logic [3:0]  ADDR_MOD_HI   = 4'h8;
    localparam logic [3:0]  ADDR_COUNT    = 4'hc;

    // ------------------------------------------------------------
    // Field positions in the control/status word
    // ------------------------------------------------------------
    localparam int          BIT_FLAG      = 0;
    localparam int          BIT_IRQ_EN    = 1;
    localparam int          BIT_CENTER    = 2;
    localparam int          BIT_CNT_RST   = 3;
    localparam int          BIT_DOWN      = 4;

    // ------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------
    localparam logic [15:0] MOD_RESET     = 16'h0000;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;
    localparam logic [15:0] COUNT_TOP     = 16'hffff;
    localparam logic [15:0] COUNT_ONE     = 16'h0001;

    // Wishbone request group
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

endpackage : ovf_pkg

//--- rtl/ovf_step.sv
`timescale 1ns/1ps
// Next counter value and overflow event for one counting clock
module ovf_step
    import ovf_pkg::*;
(
    input  wire logic [15:0] count_i,
    input  wire logic [15:0] modulo_i,
    input  wire logic        center_i,
    input  wire logic        down_i,
    output logic      [15:0] count_o,
    output logic             down_o,
    output logic             wrap_o
);

    // ------------------------------------------------------------
    // Step logic
    // ------------------------------------------------------------
    logic [15:0] top;
    assign top = (modulo_i == COUNT_ZERO) ? COUNT_TOP : modulo_i;

    // Up-count wrap or center-aligned reversal
    always_comb
    begin
        count_o = count_i + COUNT_ONE;
        down_o  = down_i;
        wrap_o  = 1'b0;
        if (center_i)
        begin
            if (!down_i && count_i >= top)
            begin
                count_o = count_i - COUNT_ONE;
                down_o  = 1'b1;
                wrap_o  = 1'b1;
            end
            else if (down_i && count_i == COUNT_ZERO)
            begin
                count_o = COUNT_ONE;
                down_o  = 1'b0;
            end
            else if (down_i)
            begin
                count_o = count_i - COUNT_ONE;
            end
        end
        else
        begin
            down_o = 1'b0;
            if (count_i >= top)
            begin
                count_o = COUNT_ZERO;
                wrap_o  = 1'b1;
            end
        end
    end

endmodule : ovf_step

//--- rtl/ovf_counter.sv
`timescale 1ns/1ps
// Functional notes
// - Interrupt output high while flag set and enable set; polling otherwise.
// - Free run 0000 to ffff, wrap to 0000, flag set on wrap.
// - Nonzero modulo: restart at 0000 after modulo value, flag set then.
// - Center mode: count down after modulo, flag set on that step.
// - Debug active freezes counter and read coherency latch.
// - After one modulo byte write, no flag until other byte written.
// - Modulo resets to 0000; zero means free running.
module ovf_counter
    import ovf_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cnt_tick_i,
    input  wire logic        debug_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic        down;
        logic [15:0] modulo;
        logic        half_lo;
        logic        half_hi;
        logic        overflow_flag;
        logic        overflow_irq_enable;
        logic        center_aligned_select;
        logic [7:0]  count_hi_latch;
        logic        ack;
        logic [31:0] rdata;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    wb_req_t req;

    logic [15:0] step_count;
    logic        step_down;
    logic        step_wrap;
    logic        wr;
    logic        rd;
    logic        pending;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

    // Single cycle access, ack cleared the cycle after
    assign wr      = req.cyc && req.stb && req.we && !st_ff.ack;
    assign rd      = req.cyc && req.stb && !req.we && !st_ff.ack;
    assign pending = st_ff.half_lo || st_ff.half_hi;

    // ------------------------------------------------------------
    // Counter step
    // ------------------------------------------------------------
    ovf_step u_step (
        .count_i  (st_ff.count),
        .modulo_i (st_ff.modulo),
        .center_i (st_ff.center_aligned_select),
        .down_i   (st_ff.down),
        .count_o  (step_count),
        .down_o   (step_down),
        .wrap_o   (step_wrap)
    );

    // Read mux for the bus
    function automatic logic [31:0] read_word(input state_t s,
                                              input logic [3:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            ADDR_CTRL:
            begin
                w[BIT_FLAG]   = s.overflow_flag;
                w[BIT_IRQ_EN] = s.overflow_irq_enable;
                w[BIT_CENTER] = s.center_aligned_select;
                w[BIT_DOWN]   = s.down;
            end
            ADDR_MOD_LO: w[7:0]  = s.modulo[7:0];
            ADDR_MOD_HI: w[7:0]  = s.modulo[15:8];
            ADDR_COUNT:  w[15:0] = {s.count_hi_latch, s.count[7:0]};
            default:     w = 32'h0000_0000;
        endcase
        return w;
    endfunction : read_word

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.ack   = wr || rd;
        nxt_st.rdata = rd ? read_word(st_ff, req.adr) : 32'h0000_0000;

        // Counting clock, frozen in debug
        if (cnt_tick_i && !debug_i)
        begin
            nxt_st.count = step_count;
            nxt_st.down  = step_down;
            if (step_wrap && !pending)
                nxt_st.overflow_flag = 1'b1;
        end

        // Latch high count byte on a read, kept during debug
        if (rd && req.adr == ADDR_COUNT && !debug_i)
            nxt_st.count_hi_latch = st_ff.count[15:8];

        if (wr && req.sel[0])
        begin
            unique case (req.adr)
                ADDR_CTRL:
                begin
                    // Write one to clear; set wins over clear
                    if (req.dat[BIT_FLAG] && !(cnt_tick_i && !debug_i
                        && step_wrap && !pending))
                        nxt_st.overflow_flag = 1'b0;
                    nxt_st.overflow_irq_enable   = req.dat[BIT_IRQ_EN];
                    nxt_st.center_aligned_select = req.dat[BIT_CENTER];
                    if (req.dat[BIT_CNT_RST])
                    begin
                        nxt_st.count = COUNT_ZERO;
                        nxt_st.down  = 1'b0;
                    end
                end
                ADDR_MOD_LO:
                begin
                    nxt_st.modulo[7:0] = req.dat[7:0];
                    nxt_st.half_lo     = !st_ff.half_hi;
                    nxt_st.half_hi     = 1'b0;
                end
                ADDR_MOD_HI:
                begin
                    nxt_st.modulo[15:8] = req.dat[7:0];
                    nxt_st.half_hi      = !st_ff.half_lo;
                    nxt_st.half_lo      = 1'b0;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff        <= '0;
            st_ff.modulo <= MOD_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdata;
    // Level interrupt while flag and enable set
    assign irq_o    = st_ff.overflow_flag && st_ff.overflow_irq_enable;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence wrap_seen;
        cnt_tick_i && !debug_i && step_wrap && !pending;
    endsequence

    // Counting edge in up mode with no register write
    sequence up_tick;
        cnt_tick_i && !debug_i && !wr && !st_ff.center_aligned_select;
    endsequence

    // Counting edge in center mode with no register write
    sequence center_tick;
        cnt_tick_i && !debug_i && !wr && st_ff.center_aligned_select;
    endsequence

    chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap_seen ##0 (st_ff.overflow_irq_enable && !wr) |=> irq_o)
        else $error("irq not raised on wrap");

    chk_free_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (cnt_tick_i && !debug_i && st_ff.modulo == COUNT_ZERO
         && !st_ff.center_aligned_select && st_ff.count == COUNT_TOP
         && !wr) |=> st_ff.count == COUNT_ZERO)
        else $error("free run wrap wrong");

    chk_mod_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (cnt_tick_i && !debug_i && st_ff.modulo != COUNT_ZERO
         && !st_ff.center_aligned_select && st_ff.count == st_ff.modulo
         && !wr) |=> st_ff.count == COUNT_ZERO)
        else $error("modulo wrap wrong");

    chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap_seen |=> st_ff.overflow_flag)
        else $error("flag not set on wrap");

    chk_center_turn: assert property (
        @(posedge clk_i) disable iff (rst_i)
        center_tick ##0 (!st_ff.down && st_ff.modulo != COUNT_ZERO
                         && st_ff.count == st_ff.modulo)
        |=> st_ff.down && st_ff.count == $past(st_ff.count) - COUNT_ONE)
        else $error("center reversal wrong");

    chk_debug_freeze: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (debug_i && !wr)
        |=> $stable(st_ff.count) && $stable(st_ff.count_hi_latch))
        else $error("counter moved in debug");

    chk_half_block: assert property (@(posedge clk_i) disable iff (rst_i)
        (pending && !st_ff.overflow_flag && !(wr && req.adr == ADDR_CTRL)
         && !(wr && (req.adr == ADDR_MOD_LO || req.adr == ADDR_MOD_HI)))
        |=> !st_ff.overflow_flag)
        else $error("flag set during half write");

    chk_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.overflow_flag && !(wr && req.adr == ADDR_CTRL))
        |=> st_ff.overflow_flag)
        else $error("flag dropped without clear");

    chk_mod_reset: assert property (@(posedge clk_i)
        rst_i |=> st_ff.modulo == MOD_RESET && !st_ff.overflow_flag)
        else $error("modulo reset wrong");

    // ------------------------------------------------------------
    // Counting steps and wrap points
    // ------------------------------------------------------------
    chk_up_step: assert property (@(posedge clk_i) disable iff (rst_i)
        up_tick ##0 (st_ff.count < st_ff.modulo)
        |=> st_ff.count == $past(st_ff.count) + COUNT_ONE)
        else $error("up count step wrong");

    chk_mod_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        up_tick ##0 (!pending && st_ff.modulo != COUNT_ZERO
                     && st_ff.count == st_ff.modulo)
        |=> st_ff.overflow_flag)
        else $error("flag not set on modulo wrap");

    chk_center_down: assert property (
        @(posedge clk_i) disable iff (rst_i)
        center_tick ##0 (st_ff.down && st_ff.count != COUNT_ZERO)
        |=> st_ff.count == $past(st_ff.count) - COUNT_ONE)
        else $error("center down step wrong");

    chk_center_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        center_tick ##0 (!pending && !st_ff.down
                         && st_ff.modulo != COUNT_ZERO
                         && st_ff.count == st_ff.modulo)
        |=> st_ff.overflow_flag)
        else $error("flag not set on center turn");

    // ------------------------------------------------------------
    // Debug, interrupt and flag clearing
    // ------------------------------------------------------------
    chk_debug_noflag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (debug_i && !st_ff.overflow_flag) |=> !st_ff.overflow_flag)
        else $error("flag set in debug");

    chk_irq_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_ff.overflow_irq_enable && !wr) |=> !irq_o)
        else $error("irq raised while disabled");

    chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && req.sel[0] && req.adr == ADDR_CTRL && req.dat[BIT_FLAG]
         && !cnt_tick_i) |=> !st_ff.overflow_flag)
        else $error("flag not cleared by write");

    // ------------------------------------------------------------
    // Modulo byte pairing
    // ------------------------------------------------------------
    chk_half_arm: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && req.sel[0] && req.adr == ADDR_MOD_LO && !pending)
        |=> pending)
        else $error("low byte write did not block flag");

    chk_half_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && req.sel[0] && req.adr == ADDR_MOD_HI && st_ff.half_lo)
        |=> !pending)
        else $error("second byte write left flag blocked");

endmodule : ovf_counter

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
    import ovf_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        cnt_tick_i;
    logic        debug_i;
    wb_req_t     req;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    logic [31:0] rdat;
    int          fail_count;
    int          n_compared;

    ovf_counter dut_u
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cnt_tick_i (cnt_tick_i),
        .debug_i    (debug_i),
        .wb_cyc_i   (req.cyc),
        .wb_stb_i   (req.stb),
        .wb_we_i    (req.we),
        .wb_adr_i   (req.adr),
        .wb_sel_i   (req.sel),
        .wb_dat_i   (req.dat),
        .wb_dat_o   (wb_dat_o),
        .wb_ack_o   (wb_ack_o),
        .irq_o      (irq_o)
    );

    // Free running clock, 5 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Bus, tick and compare tasks
    // ------------------------------------------------------------
    // One classic cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [3:0] adr,
                           input logic [31:0] dat);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr,
                 sel: 4'hf, dat: dat};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 50)
            chk("ack", 32'h1, 32'h0);
        rdat = wb_dat_o;
        req <= '0;
        @(posedge clk_i);
    endtask : wb_xfer

    task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat);
    endtask : wr

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Read a register and compare it
    task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        chk($sformatf("reg %h", adr), exp, rdat);
    endtask : rd

    // Counting clock enable for n edges
    task automatic step(input int n);
        repeat (n)
        begin
            cnt_tick_i <= 1'b1;
            @(posedge clk_i);
        end
        cnt_tick_i <= 1'b0;
    endtask : step

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    // Hang guard, well beyond the full free run wrap
    initial
    begin
        #(100000 * 5);
        fail_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        fail_count = 0;
        n_compared = 0;
        rst_i = 1'b1;
        cnt_tick_i = 1'b0;
        debug_i = 1'b0;
        req = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values and an unmapped place
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_MOD_LO, 32'h0);
        rd(ADDR_MOD_HI, 32'h0);
        rd(4'h2, 32'h0);
        chk("irq", 32'h0, {31'h0, irq_o});
        // Modulo three, counter restarted before counting
        wr(ADDR_MOD_LO, 32'h3);
        wr(ADDR_MOD_HI, 32'h0);
        wr(ADDR_CTRL, 32'h8);
        step(3);
        rd(ADDR_COUNT, 32'h3);
        rd(ADDR_CTRL, 32'h0);
        step(1);
        rd(ADDR_CTRL, 32'h1);
        chk("irq", 32'h0, {31'h0, irq_o});
        wr(ADDR_CTRL, 32'h2);
        chk("irq", 32'h1, {31'h0, irq_o});
        step(5);
        rd(ADDR_CTRL, 32'h3);
        wr(ADDR_CTRL, 32'h3);
        rd(ADDR_CTRL, 32'h2);
        chk("irq", 32'h0, {31'h0, irq_o});
        // Debug holds the count still
        wr(ADDR_CTRL, 32'h8);
        debug_i <= 1'b1;
        step(10);
        debug_i <= 1'b0;
        step(3);
        rd(ADDR_CTRL, 32'h0);
        step(1);
        rd(ADDR_CTRL, 32'h1);
        wr(ADDR_CTRL, 32'h1);
        // One modulo byte written, flag held off
        wr(ADDR_MOD_LO, 32'h2);
        wr(ADDR_CTRL, 32'h8);
        step(10);
        rd(ADDR_CTRL, 32'h0);
        wr(ADDR_MOD_HI, 32'h0);
        wr(ADDR_CTRL, 32'h8);
        step(3);
        rd(ADDR_CTRL, 32'h1);
        // Center mode, flag on the turn at modulo
        wr(ADDR_CTRL, 32'hd);
        step(2);
        wb_xfer(1'b0, ADDR_CTRL, 32'h0);
        chk("flag", 32'h0, rdat & 32'h1);
        step(1);
        rd(ADDR_CTRL, 32'h15);
        step(1);
        rd(ADDR_COUNT, 32'h0);
        // Reset again in mid run, modulo back to zero
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ADDR_MOD_LO, 32'h0);
        rd(ADDR_CTRL, 32'h0);
        // Free run over the full range
        wr(ADDR_MOD_LO, 32'h0);
        wr(ADDR_MOD_HI, 32'h0);
        wr(ADDR_CTRL, 32'h9);
        step(65535);
        rd(ADDR_CTRL, 32'h0);
        // Count reads in debug leave the high byte latch alone
        debug_i <= 1'b1;
        rd(ADDR_COUNT, 32'h00ff);
        rd(ADDR_COUNT, 32'h00ff);
        debug_i <= 1'b0;
        rd(ADDR_COUNT, 32'h00ff);
        rd(ADDR_COUNT, 32'hffff);
        step(1);
        rd(ADDR_CTRL, 32'h1);
        report_and_stop();
    end
endmodule : tb
